// >>> bench/fpc_core_properties.sv
module fpc_core_chk (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic special_mode_flag,
	input wire logic [3:0] pin_direction_reg,
	input wire fpc_pkg::fpc_pins_s pwm_pins
);
	logic rd_acc;
	logic [7:0] a;
	assign rd_acc = hsel && hready && htrans[1] && !hwrite;
	assign a = haddr[7:0];
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("hrdata upper bits set");
	a_rdata_hold: assert property (!rd_acc |=> $stable(hrdata))
		else $error("hrdata changed without read");
	a_unmapped_zero: assert property (
		rd_acc && a >= 8'h58 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_pres_width: assert property (
		rd_acc && a == 8'h0c |=> !hrdata[7])
		else $error("prescale counter wider than 7 bits");
	a_test_clear: assert property (
		rd_acc && a == 8'h54 && !special_mode_flag
		|=> hrdata == 32'h0)
		else $error("test bits set outside special mode");
	a_dir_out: assert property ($past(nrst) |->
		(pwm_pins.oe_n & $past(pin_direction_reg)) == 4'h0)
		else $error("direction bit not honoured");
	a_level_off: assert property ($past(nrst) |->
		(pwm_pins.level & pwm_pins.oe_n & $past(pwm_pins.oe_n)) == 4'h0)
		else $error("disabled pin not low");
	c_cnt_wr: cover property (hsel && htrans[1] && hwrite && a == 8'h20);
	c_level: cover property (pwm_pins.level[0]);
	c_tst_rd: cover property (rd_acc && a == 8'h54);
endmodule // fpc_core_chk

bind fpc_core fpc_core_chk fpc_core_chk_i (.core_clk(core_clk),
	.nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.special_mode_flag(special_mode_flag),
	.pin_direction_reg(pin_direction_reg), .pwm_pins(pwm_pins));

// >>> bench/test_fpc_core.sv
`define CHK(g, e) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("ERROR %0t got %h exp %h", $time, g, e); \
	end \
end

module test_fpc_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic special_mode_flag = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [3:0] pin_direction_reg = 4'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] seed = 32'ha862dbe2;
	logic [31:0] hrdata;
	logic [31:0] rv;
	logic hready;
	fpc_pkg::fpc_pins_s pwm_pins;
	int n_errors = 0;
	int num_checks = 0;
	logic [31:0] mdl [0:255];

	always #5 core_clk = ~core_clk;

	fpc_core fpc_core_i (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(), .pwm_pins(pwm_pins),
		.special_mode_flag(special_mode_flag),
		.pin_direction_reg(pin_direction_reg));

	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic edge_rdy();
		int k;
		k = 0;
		@(posedge core_clk);
		while (hready !== 1'h1) begin
			k++;
			if (k > 50) begin
				n_errors++;
				report_and_stop();
			end
			@(posedge core_clk);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'h1, a, d, r);
		mdl[a] = d & 32'hff;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'h0, a, 32'h0, r);
		`CHK(r, mdl[a])
	endtask

	initial begin
		int n, s, p, d, t, h, c, sel, pol;
		int ctr, lo, ln, ex, h2;
		logic [7:0] a;
		for (int i = 0; i < 256; i++)
			mdl[i] = (i >= 'h30 && i < 'h50) ? 32'hff : 32'h0;
		pin_direction_reg <= 4'(rnd());
		repeat (3) @(posedge core_clk);
		nrst <= 1'h1;
		for (int i = 0; i < 22; i++)
			rd(8'(4 * i), rv);
		wr(8'hf0, rnd());
		mdl[8'hf0] = 32'h0;
		rd(8'hf0, rv);
		wr(8'h0c, 32'h7f);
		mdl[8'h0c] = 32'h0;
		rd(8'h0c, rv);
		special_mode_flag <= 1'h1;
		wr(8'h0c, 32'h05);
		rd(8'h0c, rv);
		for (int i = 0; i < 2; i++) begin
			a = 8'h10 + 8'(8 * i);
			wr(8'h54, 32'h0);
			wr(a, rnd());
			mdl[a + 8'h4] = mdl[a];
			rd(a + 8'h4, rv);
			wr(8'h54, 32'h1);
			wr(a, rnd());
			rd(a + 8'h4, rv);
		end
		special_mode_flag <= 1'h0;
		wr(8'h50, 32'h0);
		mdl[8'h54] = 32'h0;
		rd(8'h54, rv);
		for (c = 0; c < 4; c++) begin
			for (sel = 0; sel < 2; sel++) begin
				pin_direction_reg <= 4'(rnd());
				n = rnd() % 3;
				s = rnd() % 4;
				p = 2 + rnd() % 8;
				d = rnd() % p;
				pol = rnd() % 2;
				ctr = rnd() % 2;
				t = (1 << n) * (sel ? 2 * (s + 1) : 1);
				// center: up 1..p, down p-1..0, level pol while below duty
				ln = ctr ? 2 * p : p + 1;
				lo = d ? 2 * d - 1 : 0;
				ex = pol ? d + 1 : p - d;
				if (ctr)
					ex = pol ? lo : 2 * p - lo;
				a = 8'h20 + 8'(4 * c);
				wr(8'h00, 32'(n * 9));
				wr(8'h10, 32'(s));
				wr(8'h18, 32'(s));
				wr(8'h50, 32'(ctr << 3));
				wr(8'h04, 32'((sel << (4 + c)) | (pol << c)));
				wr(a + 8'h10, 32'(p));
				wr(a + 8'h20, 32'(d));
				wr(a, 32'h0);
				wr(8'h08, 32'(1 << c));
				repeat (2 * ln * t) @(posedge core_clk);
				h = 0;
				repeat (4 * ln * t) begin
					@(posedge core_clk);
					h += (pwm_pins.level[c] === 1'h1);
				end
				`CHK(h, 4 * t * ex)
				`CHK(pwm_pins.oe_n[c], 1'h0)
				wr(8'h08, 32'h0);
				bus(1'h0, a, 32'h0, rv);
				h2 = !pin_direction_reg[c];
				`CHK(pwm_pins.oe_n[c], h2)
				mdl[a] = rv;
				special_mode_flag <= 1'h1;
				wr(8'h54, 32'h4);
				bus(1'h1, a, 32'h0, rv);
				rd(a, rv);
				special_mode_flag <= 1'h0;
				wr(a, 32'h0);
				rd(a, rv);
			end
		end
		// joined pairs: even clock select slow, odd select fast
		for (c = 0; c < 4; c += 2) begin
			p = 256 + rnd() % 8;
			d = rnd() % p;
			pol = rnd() % 2;
			a = 8'(4 * c);
			wr(8'h00, c ? 32'h80 : 32'h40);
			wr(8'h50, 32'h0);
			wr(8'h04, 32'((1 << (4 + c)) | (pol << c)));
			wr(8'h30 + a, 32'(p >> 8));
			wr(8'h34 + a, 32'(p & 255));
			wr(8'h40 + a, 32'(d >> 8));
			wr(8'h44 + a, 32'(d & 255));
			wr(8'h20 + a, 32'h0);
			wr(8'h24 + a, 32'h0);
			wr(8'h08, 32'(3 << c));
			repeat (2 * (p + 1)) @(posedge core_clk);
			h = 0;
			h2 = 0;
			repeat (4 * (p + 1)) begin
				@(posedge core_clk);
				h += (pwm_pins.level[c] === 1'h1);
				h2 += (pwm_pins.level[c + 1] === 1'h1);
			end
			`CHK(h, 4 * (pol ? d + 1 : p - d))
			`CHK(h2, 0)
			wr(8'h08, 32'h0);
		end
		// period match ignored: count runs past the period
		special_mode_flag <= 1'h1;
		wr(8'h00, 32'h0);
		wr(8'h54, 32'h2);
		wr(8'h30, 32'h4);
		wr(8'h20, 32'h0);
		wr(8'h08, 32'h1);
		repeat (40) @(posedge core_clk);
		wr(8'h08, 32'h0);
		bus(1'h0, 8'h20, 32'h0, rv);
		`CHK(rv > 32'h4, 1'h1)
		special_mode_flag <= 1'h0;
		report_and_stop();
	end
endmodule // test_fpc_core

// >>> src/fpc_core.sv
// Functional notes
// - join_pair_hi: ch2 high byte, ch3 low byte, pin 2 out, ch3 clock select
// - join_pair_lo: ch0 high byte, ch1 low byte, pin 0 out, ch1 clock select
// - prescale field n gives clock A or B equal to bus clock over 2^n
// - clock select bit picks prescaled clock or scaled clock per channel
// - polarity 0 starts low, goes high at duty; polarity 1 the reverse
// - left aligned: polarity 0 duty is low time, polarity 1 high time
// - channel enable forces pin to output, direction bit untouched
// - all channels disabled stops the prescale counter
// - enable takes effect on the next selected clock tick only
// - prescale counter 7 bits, counts while any channel enabled, written only in special mode
// - scale write loads scale counter unless special load-disable set
// - scaled clock is A or B over scale plus one, then halved
// - scale counter counts down, reloads at zero, read-only
// - channel counter write clears count and loads buffered period, duty
// - special counter-reset-disable keeps count on counter write
// - counter read returns count without side effects
// - left aligned: count equal period restarts count and period
// - center aligned: count reverses direction at period
// - output takes second state when count passes duty (left aligned) or reaches duty (center aligned)
// - enabled channel counts on from the value held in its counter
// - special period-compare-disable: left aligned period match no reset
// - period and duty buffered while enabled, direct while disabled
// - global alignment bit: 0 left aligned, 1 center aligned
//
// The AHB-Lite register port and the placing of the registers were decided locally.
module fpc_core (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic special_mode_flag,
	input wire logic [3:0] pin_direction_reg,
	output fpc_pkg::fpc_pins_s pwm_pins
);

	fpc_pkg::fpc_state_s q_q;
	fpc_pkg::fpc_state_s q_d;

	////////////////////////////////////////////////////////////////////////
	// mask of low prescaler bits for a division by 2^sel
	function automatic logic [6:0] pres_mask(input logic [2:0] sel);
		pres_mask = 7'((8'h01 << sel) - 8'h01);
	endfunction

	// channel register groups: hit on base, channel in addr[3:2]
	function automatic logic grp_hit(input logic [7:0] a,
		input logic [7:0] base);
		grp_hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [7:0] rd(input fpc_pkg::fpc_state_s s,
		input logic [7:0] a);
		rd = 8'h00;
		if (grp_hit(a, fpc_pkg::OFS_CNT)) begin
			rd = s.cnt[a[3:2]];
		end else if (grp_hit(a, fpc_pkg::OFS_PER)) begin
			rd = s.per_buf[a[3:2]];
		end else if (grp_hit(a, fpc_pkg::OFS_DTY)) begin
			rd = s.dty_buf[a[3:2]];
		end else begin
			case (a)
			fpc_pkg::OFS_CLK: rd = s.clk_cfg;
			fpc_pkg::OFS_POL: rd = s.pol_cfg;
			fpc_pkg::OFS_EN: rd = {4'h0, s.en};
			fpc_pkg::OFS_PRES: rd = {1'b0, s.pres};
			fpc_pkg::OFS_SCAL0: rd = s.scale[0];
			fpc_pkg::OFS_SCNT0: rd = s.scnt[0];
			fpc_pkg::OFS_SCAL1: rd = s.scale[1];
			fpc_pkg::OFS_SCNT1: rd = s.scnt[1];
			fpc_pkg::OFS_CTL: rd = {4'h0, s.center, 3'h0};
			fpc_pkg::OFS_TST: rd = {5'h00, s.tst};
			default: rd = 8'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic pres_run;
		logic [1:0] ab_tick;
		logic [1:0] s_tick;
		logic [3:0] ch_tick;
		logic [2:0] sel;
		logic j;
		logic en;
		logic tk;
		logic pol;
		logic dn;
		logic roll;
		logic lvl;
		logic [15:0] c;
		logic [15:0] p;
		logic [15:0] t;
		logic [7:0] w;
		logic [1:0] ch;
		pres_run = 1'b0;
		ab_tick = 2'b00;
		s_tick = 2'b00;
		ch_tick = 4'h0;
		sel = 3'h0;
		j = 1'b0;
		en = 1'b0;
		tk = 1'b0;
		pol = 1'b0;
		dn = 1'b0;
		roll = 1'b0;
		lvl = 1'b0;
		c = 16'h0000;
		p = 16'h0000;
		t = 16'h0000;
		w = hwdata[7:0];
		ch = q_q.dp_addr[3:2];
		q_d = q_q;
		// test bits only survive in special mode
		if (!special_mode_flag) begin
			q_d.tst = 3'h0;
		end

		// prescaler and clocks A, B
		pres_run = |q_q.en;
		if (pres_run) begin
			q_d.pres = q_q.pres + 7'h01;
		end
		for (int k = 0; k < 2; k++) begin
			sel = (k == 0) ? q_q.clk_cfg[fpc_pkg::CLK_PSA_LSB +: 3]
				: q_q.clk_cfg[fpc_pkg::CLK_PSB_LSB +: 3];
			ab_tick[k] = pres_run
				&& ((q_q.pres & pres_mask(sel)) == pres_mask(sel));
			// scaled clocks
			if (ab_tick[k]) begin
				if (q_q.scnt[k] == 8'h00) begin
					q_d.scnt[k] = q_q.scale[k];
					q_d.shalf[k] = ~q_q.shalf[k];
					s_tick[k] = q_q.shalf[k];
				end else begin
					q_d.scnt[k] = q_q.scnt[k] - 8'h01;
				end
			end
		end
		for (int k = 0; k < fpc_pkg::NCH; k++) begin
			ch_tick[k] = q_q.pol_cfg[fpc_pkg::POL_SEL_LSB + k]
				? s_tick[k / 2] : ab_tick[k / 2];
		end

		// channels, a joined pair is handled at its even index
		for (int i = 0; i < fpc_pkg::NCH; i++) begin
			j = (i < 2) ? q_q.clk_cfg[fpc_pkg::CLK_JOIN_LO]
				: q_q.clk_cfg[fpc_pkg::CLK_JOIN_HI];
			if (!(j && (i % 2 == 1))) begin
				en = q_q.en[i];
				pol = q_q.pol_cfg[i];
				dn = q_q.down[i];
				roll = 1'b0;
				if (j) begin
					tk = ch_tick[i + 1];
					c = {q_q.cnt[i], q_q.cnt[i + 1]};
					p = {q_q.per_act[i], q_q.per_act[i + 1]};
					t = {q_q.dty_act[i], q_q.dty_act[i + 1]};
				end else begin
					tk = ch_tick[i];
					c = {8'h00, q_q.cnt[i]};
					p = {8'h00, q_q.per_act[i]};
					t = {8'h00, q_q.dty_act[i]};
				end
				if (!en) begin
					q_d.run[i] = 1'b0;
				end else if (tk) begin
					q_d.run[i] = 1'b1;
					if (!q_q.center) begin
						if (c == p && !q_q.tst[fpc_pkg::TST_PCD]) begin
							c = 16'h0000;
							roll = 1'b1;
						end else begin
							c = c + 16'h0001;
						end
					end else if (dn) begin
						if (c == 16'h0000) begin
							dn = 1'b0;
							roll = 1'b1;
							c = (p == 16'h0000) ? c : c + 16'h0001;
						end else begin
							c = c - 16'h0001;
						end
					end else if (c == p) begin
						dn = 1'b1;
						c = (c == 16'h0000) ? c : c - 16'h0001;
					end else begin
						c = c + 16'h0001;
					end
				end
				if (!j) begin
					c[15:8] = 8'h00;
				end
				// second state once the count passes duty (left aligned) or reaches it (center aligned)
				lvl = q_q.center ? (c < t) : (c <= t);
				q_d.pin_out[i] = (q_d.run[i] && en) ? (lvl ? pol : ~pol)
					: 1'b0;
				q_d.down[i] = dn;
				if (j) begin
					q_d.cnt[i] = c[15:8];
					q_d.cnt[i + 1] = c[7:0];
					q_d.pin_out[i + 1] = 1'b0;
					q_d.run[i + 1] = 1'b0;
				end else begin
					q_d.cnt[i] = c[7:0];
				end
				if (roll || !en) begin
					q_d.per_act[i] = q_q.per_buf[i];
					q_d.dty_act[i] = q_q.dty_buf[i];
					if (j) begin
						q_d.per_act[i + 1] = q_q.per_buf[i + 1];
						q_d.dty_act[i + 1] = q_q.dty_buf[i + 1];
					end
				end
			end
		end
		for (int k = 0; k < fpc_pkg::NCH; k++) begin
			q_d.pin_oe_n[k] = ~(q_q.en[k] | pin_direction_reg[k]);
		end

		// bus data phase write, wins over the counting above
		if (q_q.dp_wr) begin
			if (grp_hit(q_q.dp_addr, fpc_pkg::OFS_CNT)) begin
				if (!q_d.tst[fpc_pkg::TST_CRD]) begin
					q_d.cnt[ch] = 8'h00;
				end
				q_d.per_act[ch] = q_q.per_buf[ch];
				q_d.dty_act[ch] = q_q.dty_buf[ch];
			end else if (grp_hit(q_q.dp_addr, fpc_pkg::OFS_PER)) begin
				q_d.per_buf[ch] = w;
				if (!q_q.en[ch]) begin
					q_d.per_act[ch] = w;
				end
			end else if (grp_hit(q_q.dp_addr, fpc_pkg::OFS_DTY)) begin
				q_d.dty_buf[ch] = w;
				if (!q_q.en[ch]) begin
					q_d.dty_act[ch] = w;
				end
			end else begin
				case (q_q.dp_addr)
				fpc_pkg::OFS_CLK: q_d.clk_cfg = w;
				fpc_pkg::OFS_POL: q_d.pol_cfg = w;
				fpc_pkg::OFS_EN: q_d.en = w[3:0];
				fpc_pkg::OFS_PRES: begin
					if (special_mode_flag) begin
						q_d.pres = w[6:0];
					end
				end
				fpc_pkg::OFS_SCAL0: begin
					q_d.scale[0] = w;
					if (!q_d.tst[fpc_pkg::TST_SLD]) begin
						q_d.scnt[0] = w;
					end
				end
				fpc_pkg::OFS_SCAL1: begin
					q_d.scale[1] = w;
					if (!q_d.tst[fpc_pkg::TST_SLD]) begin
						q_d.scnt[1] = w;
					end
				end
				fpc_pkg::OFS_CTL: q_d.center = w[fpc_pkg::CTL_CENTER];
				fpc_pkg::OFS_TST: begin
					if (special_mode_flag) begin
						q_d.tst = w[2:0];
					end
				end
				default: q_d.dp_wr = 1'b0;
				endcase
			end
		end

		// bus address phase, zero wait states
		q_d.dp_wr = 1'b0;
		q_d.rdy = 1'b1;
		if (hsel && hready && htrans[1]) begin
			q_d.dp_wr = hwrite;
			q_d.dp_addr = haddr[7:0];
			if (!hwrite) begin
				// read sees any write completing this cycle
				q_d.hrdata = {24'h000000, rd(q_d, haddr[7:0])};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			q_q <= fpc_pkg::RST_STATE;
		end else begin
			q_q <= q_d;
		end
	end

	assign hrdata = q_q.hrdata;
	assign hreadyout = q_q.rdy;
	assign hresp = 1'b0;
	assign pwm_pins = '{level: q_q.pin_out, oe_n: q_q.pin_oe_n};

endmodule // fpc_core

// >>> src/fpc_pkg.sv
package fpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets (one aligned word each)
	localparam logic [7:0] OFS_CLK = 8'h00;
	localparam logic [7:0] OFS_POL = 8'h04;
	localparam logic [7:0] OFS_EN = 8'h08;
	localparam logic [7:0] OFS_PRES = 8'h0c;
	localparam logic [7:0] OFS_SCAL0 = 8'h10;
	localparam logic [7:0] OFS_SCNT0 = 8'h14;
	localparam logic [7:0] OFS_SCAL1 = 8'h18;
	localparam logic [7:0] OFS_SCNT1 = 8'h1c;
	// channel groups: base + 4 * channel
	localparam logic [7:0] OFS_CNT = 8'h20;
	localparam logic [7:0] OFS_PER = 8'h30;
	localparam logic [7:0] OFS_DTY = 8'h40;
	localparam logic [7:0] OFS_CTL = 8'h50;
	localparam logic [7:0] OFS_TST = 8'h54;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CLK_JOIN_HI = 7;
	localparam int CLK_JOIN_LO = 6;
	localparam int CLK_PSA_LSB = 3;
	localparam int CLK_PSB_LSB = 0;
	localparam int POL_SEL_LSB = 4;
	localparam int CTL_CENTER = 3;
	localparam int TST_CRD = 2;
	localparam int TST_PCD = 1;
	localparam int TST_SLD = 0;

	localparam int NCH = 4;
	localparam logic [7:0] RST_PER = 8'hff;
	localparam logic [7:0] RST_DTY = 8'hff;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe_n;
	} fpc_pins_s;

	typedef struct packed {
		logic [7:0] clk_cfg;
		logic [7:0] pol_cfg;
		logic [3:0] en;
		logic [6:0] pres;
		logic [1:0][7:0] scale;
		logic [1:0][7:0] scnt;
		logic [1:0] shalf;
		logic [3:0][7:0] cnt;
		logic [3:0][7:0] per_buf;
		logic [3:0][7:0] dty_buf;
		logic [3:0][7:0] per_act;
		logic [3:0][7:0] dty_act;
		logic [3:0] down;
		logic [3:0] run;
		logic [3:0] pin_out;
		logic [3:0] pin_oe_n;
		logic center;
		logic [2:0] tst;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic rdy;
	} fpc_state_s;

	localparam fpc_state_s RST_STATE = '{
		per_buf: {4{RST_PER}},
		per_act: {4{RST_PER}},
		dty_buf: {4{RST_DTY}},
		dty_act: {4{RST_DTY}},
		pin_oe_n: 4'hf,
		rdy: 1'b1,
		default: '0
	};

endpackage
